// ==== test/icl_monitor.sv ====
`timescale 1ns/1ps
module icl_monitor
  import icl_pkg::*;
(
  input wire logic                      aclk,
  input wire logic                      aresetn,
  input wire logic                      req,
  input wire logic                      we,
  input wire logic [icl_pkg::AW_DEV-1:0] addr,
  input wire logic [icl_pkg::DW-1:0]    wdata,
  input wire logic [icl_pkg::DW-1:0]    rdata,
  input wire logic                      ack,
  input wire logic                      irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire csw_wr = req && we && addr == REG_CSW;
  wire csw_rd = req && !we && addr == REG_CSW;
  // ==========================================================================
  // register port and completion interrupt
  ack_follows_req_a: assert property (req |=> ack)
    else $error("no acknowledge after request");
  ack_has_cause_a: assert property (ack |-> $past(req))
    else $error("acknowledge without request");
  irq_level_a: assert property (irq && !csw_wr |=> irq)
    else $error("interrupt dropped without a status write");
  ack_clears_a: assert property (csw_wr && wdata[CSW_ACK] |-> ##[1:2] !irq)
    else $error("interrupt kept after acknowledge");
  force_irq_a:
    assert property (csw_wr && wdata[CSW_DONE] && wdata[CSW_IE] && !wdata[CSW_ACK]
      |-> ##[1:2] irq) else $error("forced done raised no interrupt");
  ie_gates_a: assert property (csw_wr && !wdata[CSW_IE] |-> ##[1:2] !irq)
    else $error("interrupt while enable is clear");
  strobes_zero_a:
    assert property (csw_rd |=> !rdata[CSW_ACK] && !rdata[CSW_RST])
      else $error("strobe bit read back as one");
  reset_quiet_a: assert property (disable iff (1'b0) !aresetn |=> !irq && !ack)
    else $error("outputs active after reset");
  cover property (csw_wr && wdata[CSW_BUSY]);
  cover property (csw_wr && wdata[CSW_RST]);
  cover property ($rose(irq));
endmodule

// ==== test/image_coproc_launch_ctrl_tb.sv ====
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
`define WAITF(c) begin for (wt = 0; wt < 4000 && !(c); wt++) @(posedge aclk); \
  if (wt == 4000) begin n_errors++; report_and_stop(); end end
module image_coproc_launch_ctrl_tb;
  import icl_pkg::*;
  typedef struct packed {
    logic [1:0] ep;
    logic [3:0] pd;
    logic       ie;
    logic [15:0] code;
  } icl_row_s;
  localparam logic [31:0] BASE = 32'h0000_0100;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, mem_req, mem_ack, ucode_clk_en, uinstr_valid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, mem_addr, mem_rdata, rd, uinstr;
  logic [1:0]  bresp, rresp, rs, mem_wait;
  int          n_errors, checks, wt, cnt;
  icl_row_s    rows [4] = '{'{2'h0, 4'h0, 1'b1, 16'h8100}, '{2'h1, 4'hF, 1'b0, 16'h8101},
                            '{2'h2, 4'h3, 1'b1, 16'h8102}, '{2'h3, 4'h1, 1'b1, 16'h8103}};
  icl_if i_icl_if ();
  icl_host i_icl_host (.aclk(aclk), .aresetn(aresetn), .dev(i_icl_if),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  icl_dev i_icl_dev (.aclk(aclk), .aresetn(aresetn), .bus(i_icl_if), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .ucode_clk_en(ucode_clk_en), .uinstr_valid(uinstr_valid), .uinstr(uinstr));
  icl_monitor i_icl_monitor (.aclk(aclk), .aresetn(aresetn), .req(i_icl_if.req),
    .we(i_icl_if.we), .addr(i_icl_if.addr), .wdata(i_icl_if.wdata),
    .rdata(i_icl_if.rdata), .ack(i_icl_if.ack), .irq(i_icl_if.irq));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // ==========================================================================
  // memory: every word ends the program, code taken from its address
  always @(posedge aclk) begin
    if (mem_req && !mem_ack && mem_wait == 2'h2) begin
      mem_ack <= 1'b1;
      mem_rdata <= {1'b1, mem_addr[14:0], 16'h0000};
      mem_wait <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
        mem_wait <= mem_wait + 2'h1;
      end
    end
  end
  // ==========================================================================
  // bus tasks
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    @(posedge aclk);
    for (wt = 0; wt < 4000 && (awvalid || wvalid); wt++) begin
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      @(posedge aclk);
    end
    `WAITF(bvalid)
    `CHK(bresp, er)
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    `WAITF(arready)
    arvalid <= 1'b0;
    `WAITF(rvalid)
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic cmd(input logic [31:0] d);
    rd = 32'h1;
    for (cnt = 0; cnt < 200 && rd[0]; cnt++) axr(HA_STATUS, rd, rs);
    `CHK(rd[0], 1'b0)
    if (rd[0]) report_and_stop();
    if (d != 32'h0) axw(HA_CMD, d, RESP_OKAY);
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, mem_ack, mem_wait} = '0;
    {awaddr, araddr, wdata, mem_rdata, n_errors, checks} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axw(HA_BASE, BASE, RESP_OKAY);
    axw(HA_PARAM, 32'h0000_2000, RESP_OKAY);
    foreach (rows[i]) begin
      cmd({20'h0, rows[i].pd, 1'b0, rows[i].ie, rows[i].ep, 4'h1});
      `WAITF(ucode_clk_en)
      `WAITF(mem_req)
      `CHK(wt >= (rows[i].pd + 1) * BLOCK_CYCLES - 1, 1'b1)
      `CHK(wt <= (rows[i].pd + 1) * BLOCK_CYCLES + 3, 1'b1)
      `CHK(mem_addr, BASE + rows[i].ep)
      `WAITF(!ucode_clk_en)
      `CHK({uinstr_valid, uinstr}, {1'b1, rows[i].code, 16'h0000})
      repeat (3) @(posedge aclk);
      `CHK(i_icl_if.irq, rows[i].ie)
      cmd(32'h8);
      cmd(32'h0);
      `CHK(i_icl_if.irq, 1'b0)
      axr(HA_CSW, rd, rs);
      `CHK(rd, {rows[i].code, 4'h0, rows[i].pd, 5'h0, rows[i].ie, 2'b10})
    end
    cmd(32'h0000_0F11);
    `WAITF(ucode_clk_en)
    cmd(32'h2);
    `WAITF(!ucode_clk_en)
    cmd(32'h8);
    cmd(32'h0);
    axr(HA_CSW, rd, rs);
    `CHK({rd[31:16], rd[0], i_icl_if.irq}, 18'h0)
    cmd(32'h44);
    cmd(32'h0);
    repeat (2) @(posedge aclk);
    `CHK(i_icl_if.irq, 1'b1)
    aresetn <= 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK(i_icl_if.irq, 1'b0)
    cmd(32'h8);
    cmd(32'h0);
    axr(HA_CSW, rd, rs);
    `CHK(rd, 32'h0)
    axw(8'h20, 32'h0, RESP_SLVERR);
    axr(8'h14, rd, rs);
    `CHK(rs, RESP_SLVERR)
    report_and_stop();
  end
endmodule

// ==== verilog/icl_dev.sv ====
// Operation
// - host loads pointer, counter, then sets busy
// - finished operation sets done, raises interrupt
// - writing acknowledge clears done and interrupt
// - interrupt is a level while done persists
// - busy enables clock, fetches, runs from counter
// - fetch on demand with internal prefetch
// - busy low stops microcode clock
// - busy cleared by reset, microcode, host
// - hardware reset clears status and count register
// - end clears busy, sets done; enable gates interrupt
// - busy zero plus reset bit resets internals
// - host writing done forces the interrupt
// - entry points zero to three select operation
// - wait one to sixteen block times before fetching
// - host writes nothing while busy reads one; the host reset command writes the status word without polling busy
// - four-bit delay field loads bus timer
// - reset bit is write-only strobe
// - done means function complete, clock stopped
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module icl_dev
  import icl_pkg::*;
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  icl_if.dev                        bus,
  output logic                      mem_req,
  output logic [icl_pkg::DW-1:0]    mem_addr,
  input  wire logic                 mem_ack,
  input  wire logic [icl_pkg::DW-1:0] mem_rdata,
  output logic                      ucode_clk_en,
  output logic                      uinstr_valid,
  output logic [icl_pkg::DW-1:0]    uinstr
);
  import icl_pkg::*;

  typedef enum logic [1:0] {F_IDLE, F_DELAY, F_REQ} icl_fetch_e;

  // ==========================================================================
  // state
  logic [DW-1:0]     mpc_q;
  logic [DW-1:0]     dp_q;
  logic [DW-1:0]     tcr_q;
  logic              busy_q;
  logic              busy_d;
  logic              done_q;
  logic              done_d;
  logic              ie_q;
  logic              ie_d;
  logic [PD_W-1:0]   pd_q;
  logic [CODE_W-1:0] code_q;
  logic [DW-1:0]     rdata_q;
  logic              ack_q;
  logic              irq_q;
  logic [DW-1:0]     pf_mem [PF_DEPTH];
  logic [PF_AW:0]    wr_ptr_q;
  logic [PF_AW:0]    rd_ptr_q;
  logic [DW-1:0]     fetch_addr_q;
  logic              mem_req_q;
  logic [DW-1:0]     mem_addr_q;
  logic              stale_q;
  logic [DLY_W-1:0]  dly_q;
  icl_fetch_e        fst_q;
  logic              uvalid_q;
  logic [DW-1:0]     uinstr_q;

  // ==========================================================================
  // decode
  wire               wr_en    = bus.req & bus.we;
  wire               rd_en    = bus.req & ~bus.we;
  wire               csw_wr   = wr_en & (bus.addr == REG_CSW);
  wire               mpc_wr   = wr_en & (bus.addr == REG_MPC);
  wire               dp_wr    = wr_en & (bus.addr == REG_DP);
  wire               launch   = csw_wr & bus.wdata[CSW_BUSY] & ~busy_q;
  wire               soft_rst = csw_wr & bus.wdata[CSW_RST];
  wire [PF_AW:0]     pf_count = wr_ptr_q - rd_ptr_q;
  wire               pf_empty = (pf_count == '0);
  wire               pf_full  = (pf_count == (PF_AW+1)'(PF_DEPTH));
  wire [DW-1:0]      instr    = pf_mem[rd_ptr_q[PF_AW-1:0]];
  wire               exec     = busy_q & ~pf_empty;
  wire               ucode_end = exec & instr[UI_END_BIT];
  wire               f_req    = (fst_q == F_REQ);
  wire               push     = f_req & mem_ack & busy_q & ~stale_q;
  wire [PF_AW:0]     cnt_next = pf_count + (PF_AW+1)'(1);
  wire [DLY_W-1:0]   dly_load = DLY_W'((int'(pd_q) + 1) * BLOCK_CYCLES - 1);
  wire               done_set = ucode_end | (csw_wr & bus.wdata[CSW_DONE]);
  wire               done_clr = csw_wr & bus.wdata[CSW_ACK];
  wire [DW-1:0]      csw_rd   = {code_q, 4'h0, pd_q, 1'b0, 3'h0, 1'b0, ie_q, done_q, busy_q};
  wire [DW-1:0]      rd_mux   = (bus.addr == REG_MPC) ? mpc_q :
                                (bus.addr == REG_DP)  ? dp_q  :
                                (bus.addr == REG_CSW) ? csw_rd : tcr_q;

  // ==========================================================================
  // status word
  always_comb begin
    busy_d = busy_q;
    if (ucode_end) begin
      busy_d = 1'b0;
    end
    if (csw_wr) begin
      busy_d = bus.wdata[CSW_BUSY] & ~bus.wdata[CSW_RST];
    end
  end

  // set wins over the acknowledge strobe; the strobe itself is not stored
  assign done_d = done_set | (done_q & ~done_clr);
  assign ie_d   = csw_wr ? bus.wdata[CSW_IE] : ie_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= CSW_RESET_VAL[CSW_BUSY];
      done_q <= CSW_RESET_VAL[CSW_DONE];
      ie_q   <= CSW_RESET_VAL[CSW_IE];
      pd_q   <= '0;
      irq_q  <= 1'b0;
    end else begin
      busy_q <= busy_d;
      done_q <= done_d;
      ie_q   <= ie_d;
      irq_q  <= done_d & ie_d;
      if (csw_wr) begin
        pd_q <= bus.wdata[CSW_PD_LSB +: PD_W];
      end
    end
  end

  // ==========================================================================
  // pointers, count register and completion code
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_rst) begin
      mpc_q  <= '0;
      dp_q   <= '0;
      tcr_q  <= '0;
      code_q <= '0;
    end else begin
      if (mpc_wr) begin
        mpc_q <= bus.wdata;
      end else if (exec) begin
        mpc_q <= mpc_q + 32'h0000_0001;
      end
      if (dp_wr) begin
        dp_q <= bus.wdata;
      end
      if (launch) begin
        tcr_q <= '0;
      end else if (exec) begin
        tcr_q <= tcr_q + 32'h0000_0001;
      end
      if (ucode_end) begin
        code_q <= instr[CSW_CODE_LSB +: CODE_W];
      end
    end
  end

  // ==========================================================================
  // register read port, answer one cycle after request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= '0;
      ack_q   <= 1'b0;
    end else begin
      ack_q <= bus.req;
      if (rd_en) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // ==========================================================================
  // prefetch buffer, emptied whenever busy is low
  always_ff @(posedge aclk) begin
    if (push) begin
      pf_mem[wr_ptr_q[PF_AW-1:0]] <= mem_rdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !busy_q || ucode_end) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + (PF_AW+1)'(1);
      end
      if (exec) begin
        rd_ptr_q <= rd_ptr_q + (PF_AW+1)'(1);
      end
    end
  end

  // ==========================================================================
  // fetch engine: priority delay, then a burst until the buffer is full
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fst_q        <= F_IDLE;
      fetch_addr_q <= '0;
      mem_req_q    <= 1'b0;
      mem_addr_q   <= '0;
      dly_q        <= '0;
      stale_q      <= 1'b0;
    end else begin
      // a request left open when busy fell is finished but its word dropped
      stale_q <= f_req & ~mem_ack & (stale_q | ~busy_q);
      if (launch) begin
        fetch_addr_q <= mpc_q;
      end else if (push) begin
        fetch_addr_q <= fetch_addr_q + 32'h0000_0001;
      end
      unique case (fst_q)
        F_IDLE: begin
          if (busy_q && !pf_full && !ucode_end) begin
            fst_q <= F_DELAY;
            dly_q <= dly_load;
          end
        end
        F_DELAY: begin
          if (!busy_q) begin
            fst_q <= F_IDLE;
          end else if (dly_q == '0) begin
            fst_q      <= F_REQ;
            mem_req_q  <= 1'b1;
            mem_addr_q <= fetch_addr_q;
          end else begin
            dly_q <= dly_q - DLY_W'(1);
          end
        end
        F_REQ: begin
          if (mem_ack) begin
            if (push && cnt_next != (PF_AW+1)'(PF_DEPTH) && !ucode_end) begin
              mem_addr_q <= fetch_addr_q + 32'h0000_0001;
            end else begin
              mem_req_q <= 1'b0;
              fst_q     <= F_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // execution stream
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uvalid_q <= 1'b0;
      uinstr_q <= '0;
    end else begin
      uvalid_q <= exec;
      if (exec) begin
        uinstr_q <= instr;
      end
    end
  end

  assign bus.rdata    = rdata_q;
  assign bus.ack      = ack_q;
  assign bus.irq      = irq_q;
  assign mem_req      = mem_req_q;
  assign mem_addr     = mem_addr_q;
  assign ucode_clk_en = busy_q;
  assign uinstr_valid = uvalid_q;
  assign uinstr       = uinstr_q;

endmodule

// ==== verilog/icl_host.sv ====
`timescale 1ns/1ps
module icl_host
  import icl_pkg::*;
(
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  icl_if.host                         dev,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [icl_pkg::DW-1:0] s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [icl_pkg::DW-1:0]      s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);
  import icl_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_POLL, H_POLL_W, H_WR, H_WR_W} icl_hstate_e;
  typedef enum logic [1:0] {OP_LAUNCH, OP_RESET, OP_FORCE, OP_ACK} icl_op_e;

  // ==========================================================================
  // AXI4-Lite slave
  logic              awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic              aw_hold_q, w_hold_q;
  logic [7:0]        aw_addr_q;
  logic [DW-1:0]     w_data_q;
  logic [3:0]        w_strb_q;
  logic [1:0]        bresp_q, rresp_q;
  logic [DW-1:0]     rdata_q;
  logic [DW-1:0]     base_q, param_q, csw_snap_q;
  logic [1:0]        ep_q;
  logic              ie_q;
  logic [PD_W-1:0]   pd_q;
  icl_hstate_e       st_q;
  icl_op_e           op_q;
  logic [1:0]        step_q;
  logic              req_q, we_q;
  logic [AW_DEV-1:0] addr_q;
  logic [DW-1:0]     wdata_q;

  wire aw_take  = s_axi_awvalid & awready_q;
  wire w_take   = s_axi_wvalid & wready_q;
  wire do_wr    = aw_hold_q & w_hold_q & ~bvalid_q;
  wire bvalid_d = do_wr | (bvalid_q & ~s_axi_bready);
  wire aw_hold_d = (aw_hold_q | aw_take) & ~do_wr;
  wire w_hold_d  = (w_hold_q | w_take) & ~do_wr;
  wire ar_take  = s_axi_arvalid & arready_q;
  wire rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
  wire seq_busy = (st_q != H_IDLE);
  wire wr_map   = (aw_addr_q == HA_BASE) | (aw_addr_q == HA_PARAM) | (aw_addr_q == HA_CMD);
  wire rd_map   = (s_axi_araddr == HA_BASE) | (s_axi_araddr == HA_PARAM) |
                  (s_axi_araddr == HA_STATUS) | (s_axi_araddr == HA_CSW) |
                  (s_axi_araddr == HA_CMD);
  wire cmd_go   = do_wr & (aw_addr_q == HA_CMD) & w_strb_q[0] & ~seq_busy;
  wire [DW-1:0] wmask;
  wire [DW-1:0] rd_mux = (s_axi_araddr == HA_BASE)   ? base_q  :
                         (s_axi_araddr == HA_PARAM)  ? param_q :
                         (s_axi_araddr == HA_STATUS) ? {30'h0, dev.irq, seq_busy} :
                         (s_axi_araddr == HA_CSW)    ? csw_snap_q : 32'h0000_0000;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_mask
      assign wmask[gi*8 +: 8] = {8{w_strb_q[gi]}};
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bresp_q   <= RESP_OKAY;
      rresp_q   <= RESP_OKAY;
      rdata_q   <= '0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q  <= w_hold_d;
      bvalid_q  <= bvalid_d;
      rvalid_q  <= rvalid_d;
      awready_q <= ~aw_hold_d & ~bvalid_d;
      wready_q  <= ~w_hold_d & ~bvalid_d;
      arready_q <= ~rvalid_d;
      if (aw_take) begin
        aw_addr_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end
      if (ar_take) begin
        rdata_q <= rd_mux;
        rresp_q <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ==========================================================================
  // command registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_q  <= '0;
      param_q <= '0;
      ep_q    <= '0;
      ie_q    <= 1'b0;
      pd_q    <= '0;
    end else if (do_wr) begin
      if (aw_addr_q == HA_BASE) begin
        base_q <= (base_q & ~wmask) | (w_data_q & wmask);
      end
      if (aw_addr_q == HA_PARAM) begin
        param_q <= (param_q & ~wmask) | (w_data_q & wmask);
      end
      if (cmd_go) begin
        ep_q <= w_data_q[CMD_EP_LSB +: 2];
        ie_q <= w_data_q[CMD_IE];
        pd_q <= w_data_q[CMD_PD_LSB +: PD_W];
      end
    end
  end

  // ==========================================================================
  // device sequencer
  wire icl_op_e op_pick = w_data_q[CMD_RESET]  ? OP_RESET :
                          w_data_q[CMD_ACK]    ? OP_ACK   :
                          w_data_q[CMD_FORCE]  ? OP_FORCE : OP_LAUNCH;
  wire any_cmd = w_data_q[CMD_RESET] | w_data_q[CMD_ACK] | w_data_q[CMD_FORCE] |
                 w_data_q[CMD_LAUNCH];
  wire [DW-1:0] csw_common = DW'({pd_q, 8'h00}) | DW'({ie_q, 2'b00});
  wire [DW-1:0] csw_word =
    (op_q == OP_LAUNCH) ? (csw_common | DW'(1) << CSW_BUSY) :
    (op_q == OP_RESET)  ? (csw_common | DW'(1) << CSW_RST)  :
    (op_q == OP_FORCE)  ? (csw_common | DW'(1) << CSW_DONE) :
                          (csw_common | DW'(1) << CSW_ACK);
  wire [AW_DEV-1:0] step_addr = (step_q == 2'h0) ? REG_DP :
                                (step_q == 2'h1) ? REG_MPC : REG_CSW;
  wire [DW-1:0] step_data = (step_q == 2'h0) ? param_q :
                            (step_q == 2'h1) ? base_q + DW'(ep_q) :
                                               csw_word;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q       <= H_IDLE;
      op_q       <= OP_LAUNCH;
      step_q     <= '0;
      req_q      <= 1'b0;
      we_q       <= 1'b0;
      addr_q     <= '0;
      wdata_q    <= '0;
      csw_snap_q <= '0;
    end else begin
      req_q <= 1'b0;
      unique case (st_q)
        H_IDLE: begin
          if (cmd_go && any_cmd) begin
            op_q   <= op_pick;
            step_q <= (op_pick == OP_LAUNCH) ? 2'h0 : 2'h2;
            st_q   <= (op_pick == OP_RESET) ? H_WR : H_POLL;
          end
        end
        H_POLL: begin
          req_q  <= 1'b1;
          we_q   <= 1'b0;
          addr_q <= REG_CSW;
          st_q   <= H_POLL_W;
        end
        H_POLL_W: begin
          if (dev.ack) begin
            csw_snap_q <= dev.rdata;
            st_q <= dev.rdata[CSW_BUSY] ? H_POLL : H_WR;
          end
        end
        H_WR: begin
          req_q   <= 1'b1;
          we_q    <= 1'b1;
          addr_q  <= step_addr;
          wdata_q <= step_data;
          st_q    <= H_WR_W;
        end
        H_WR_W: begin
          if (dev.ack) begin
            step_q <= step_q + 2'h1;
            st_q   <= (step_q == 2'h2) ? H_IDLE : H_WR;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign dev.req       = req_q;
  assign dev.we        = we_q;
  assign dev.addr      = addr_q;
  assign dev.wdata     = wdata_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

endmodule

// ==== verilog/icl_if.sv ====
`timescale 1ns/1ps
interface icl_if;
  logic                        req;
  logic                        we;
  logic [icl_pkg::AW_DEV-1:0]  addr;
  logic [icl_pkg::DW-1:0]      wdata;
  logic [icl_pkg::DW-1:0]      rdata;
  logic                        ack;
  logic                        irq;

  modport dev (input req, input we, input addr, input wdata,
               output rdata, output ack, output irq);
  modport host (output req, output we, output addr, output wdata,
                input rdata, input ack, input irq);
endinterface

// ==== verilog/icl_pkg.sv ====
package icl_pkg;

  // ==========================================================================
  // widths
  localparam int DW     = 32;
  localparam int AW_DEV = 2;
  localparam int PD_W   = 4;
  localparam int CODE_W = 16;

  // ==========================================================================
  // device register indices
  localparam logic [AW_DEV-1:0] REG_MPC = 2'h0;
  localparam logic [AW_DEV-1:0] REG_DP  = 2'h1;
  localparam logic [AW_DEV-1:0] REG_CSW = 2'h2;
  localparam logic [AW_DEV-1:0] REG_TCR = 2'h3;

  // ==========================================================================
  // control status word fields
  localparam int CSW_BUSY    = 0;
  localparam int CSW_DONE    = 1;
  localparam int CSW_IE      = 2;
  localparam int CSW_ACK     = 3;
  localparam int CSW_RST     = 7;
  localparam int CSW_PD_LSB  = 8;
  localparam int CSW_CODE_LSB = 16;
  localparam logic [DW-1:0] CSW_RESET_VAL = 32'h0000_0000;

  // ==========================================================================
  // microinstruction format
  localparam int UI_END_BIT = 31;

  // ==========================================================================
  // timing
  localparam int CLK_NS        = 20;
  localparam int BLOCK_TIME_NS = 160;
  localparam int BLOCK_CYCLES  = (BLOCK_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int DLY_W         = 8;

  // ==========================================================================
  // prefetch buffer
  localparam int PF_DEPTH = 4;
  localparam int PF_AW    = 2;

  // ==========================================================================
  // microprogram entry points, word offsets from the microprogram base
  typedef enum logic [1:0] {
    EP_LOAD_COEF,
    EP_HSCALE,
    EP_VSCALE,
    EP_HSCALE_RGB
  } icl_entry_e;

  // ==========================================================================
  // controller AXI4-Lite map
  localparam logic [7:0] HA_BASE   = 8'h00;
  localparam logic [7:0] HA_PARAM  = 8'h04;
  localparam logic [7:0] HA_CMD    = 8'h08;
  localparam logic [7:0] HA_STATUS = 8'h0C;
  localparam logic [7:0] HA_CSW    = 8'h10;
  localparam int CMD_LAUNCH = 0;
  localparam int CMD_RESET  = 1;
  localparam int CMD_FORCE  = 2;
  localparam int CMD_ACK    = 3;
  localparam int CMD_EP_LSB = 4;
  localparam int CMD_IE     = 6;
  localparam int CMD_PD_LSB = 8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
